// ### rtl/exec_map.svh
// register offsets, field positions and reset values of the execute block
// assumes: included by bare name from every file that needs a number
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// register port offsets
`define WORK_REG_OFS   4'h0
`define FLAGS_REG_OFS  4'h1
`define STATE_REG_OFS  4'h2

// field positions inside the flags register
`define FLAG_C_POS     0
`define FLAG_DC_POS    1
`define FLAG_Z_POS     2

// field positions inside the state register
`define STATE_SKIP_POS 0

// reset values and idle answers
`define WORK_RESET     8'h00
`define FLAGS_RESET    3'h0
`define RDATA_IDLE     8'h00

`endif

// ### rtl/exec_pkg.sv
// types shared by the execute datapath and its users
// assumes: the decoder drives instruction codes of type op_t
package exec_pkg;

    // decoded instruction classes handed over by the decoder
    typedef enum logic [3:0] {
        op_no_operation,
        op_add_immediate,
        op_add_working_to_file,
        op_and_immediate,
        op_and_working_with_file,
        op_bit_clear_op,
        op_bit_set_op,
        op_test_bit_skip_if_one,
        op_test_bit_skip_if_zero
    } op_t;

    // sequencer states: normal issue or the substituted idle cycle
    typedef enum logic {
        st_execute,
        st_skip_nop
    } state_t;

endpackage

// ### rtl/carry_adder.sv
// eight-bit adder with carry out of the top bit and of the low nibble
// assumes: purely combinational, operands stable within the cycle
`timescale 1ns/1ps

module carry_adder #(
    parameter int DATA_W = 8
) (
    // operands
    input  wire logic [DATA_W-1:0] a,
    input  wire logic [DATA_W-1:0] b,
    // results
    output logic      [DATA_W-1:0] sum,
    output logic                   carry_out,
    output logic                   digit_carry_out
);

    logic [DATA_W:0] full_sum;
    logic [4:0]      low_sum;

    // full width sum keeps the top carry, nibble sum the half carry
    assign full_sum        = {1'b0, a} + {1'b0, b};
    assign low_sum         = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    assign sum             = full_sum[DATA_W-1:0];
    assign carry_out       = full_sum[DATA_W];
    assign digit_carry_out = low_sum[4];

endmodule

// ### rtl/bit_select_unit.sv
// single bit clear, set and test on one operand byte
// assumes: purely combinational, index always within the byte
`timescale 1ns/1ps

module bit_select_unit #(
    parameter int DATA_W = 8,
    parameter int IDX_W  = 3
) (
    // operand and bit position
    input  wire logic [DATA_W-1:0] value,
    input  wire logic [IDX_W-1:0]  bit_idx,
    // results
    output logic      [DATA_W-1:0] cleared,
    output logic      [DATA_W-1:0] set,
    output logic                   tested
);

    logic [DATA_W-1:0] one_hot;

    // one-hot mask picks the bit, the rest of the byte passes untouched
    assign one_hot = DATA_W'(1) << bit_idx;
    assign cleared = value & ~one_hot;
    assign set     = value | one_hot;
    assign tested  = value[bit_idx];

endmodule

// ### rtl/add_and_bit_ops_execute.sv
// execute stage for add, and, bit clear/set and bit test-and-skip
// assumes: decoder offers one decoded instruction per cycle; file array
// reads asynchronously and writes on the edge where file_we is high
`timescale 1ns/1ps
`include "exec_map.svh"

module add_and_bit_ops_execute #(
    parameter int DATA_W  = 8,
    parameter int FADDR_W = 7,
    parameter int IDX_W   = 3,
    parameter int RADDR_W = 4
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // decoded instruction from the decoder
    input  wire logic                 instr_valid,
    input  wire exec_pkg::op_t        instr_op,
    input  wire logic [DATA_W-1:0]    instr_literal,
    input  wire logic [FADDR_W-1:0]   instr_file_addr,
    input  wire logic                 instr_dest,
    input  wire logic [IDX_W-1:0]     instr_bit_idx,
    // file register array
    input  wire logic [DATA_W-1:0]    file_rdata,
    output logic                      file_we,
    output logic      [FADDR_W-1:0]   file_waddr,
    output logic      [DATA_W-1:0]    file_wdata,
    // sequencing and status
    output logic                      skip_nop,
    output logic      [DATA_W-1:0]    work_value,
    output logic                      carry_flag,
    output logic                      digit_carry_flag,
    output logic                      zero_flag,
    // register port
    input  wire logic [RADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // state

    exec_pkg::state_t  state_reg;
    exec_pkg::state_t  state_next;
    logic [DATA_W-1:0] work_reg;
    logic [DATA_W-1:0] work_next;
    logic [2:0]        flags_reg;
    logic [2:0]        flags_next;
    logic              file_we_reg;
    logic              file_we_next;
    logic [FADDR_W-1:0] file_waddr_reg;
    logic [DATA_W-1:0] file_wdata_reg;
    logic [DATA_W-1:0] file_wdata_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // result is zero over the full byte
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == '0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire take       = instr_valid && (state_reg == exec_pkg::st_execute);
    wire op_add_imm = (instr_op == exec_pkg::op_add_immediate);
    wire op_add_fil = (instr_op == exec_pkg::op_add_working_to_file);
    wire op_and_imm = (instr_op == exec_pkg::op_and_immediate);
    wire op_and_fil = (instr_op == exec_pkg::op_and_working_with_file);
    wire op_bclr    = (instr_op == exec_pkg::op_bit_clear_op);
    wire op_bset    = (instr_op == exec_pkg::op_bit_set_op);
    wire op_t_one   = (instr_op == exec_pkg::op_test_bit_skip_if_one);
    wire op_t_zero  = (instr_op == exec_pkg::op_test_bit_skip_if_zero);
    wire is_add     = op_add_imm || op_add_fil;
    wire is_and     = op_and_imm || op_and_fil;
    wire is_imm     = op_add_imm || op_and_imm;
    wire is_reg_alu = op_add_fil || op_and_fil;

    ////////////////////////////////////////////////////////////////////////
    // operands and datapath

    // forward a write still in flight: the array only takes it next edge
    wire fwd_hit = file_we_reg && (file_waddr_reg == instr_file_addr);
    wire [DATA_W-1:0] file_operand = fwd_hit ? file_wdata_reg : file_rdata;
    wire [DATA_W-1:0] opnd_b = is_imm ? instr_literal : file_operand;

    wire [DATA_W-1:0] add_sum;
    wire              add_c;
    wire              add_dc;
    wire [DATA_W-1:0] bit_cleared;
    wire [DATA_W-1:0] bit_set;
    wire              bit_tested;

    carry_adder #(
        .DATA_W          (DATA_W)
    ) u_adder (
        .a               (work_reg),
        .b               (opnd_b),
        .sum             (add_sum),
        .carry_out       (add_c),
        .digit_carry_out (add_dc)
    );

    bit_select_unit #(
        .DATA_W  (DATA_W),
        .IDX_W   (IDX_W)
    ) u_bits (
        .value   (file_operand),
        .bit_idx (instr_bit_idx),
        .cleared (bit_cleared),
        .set     (bit_set),
        .tested  (bit_tested)
    );

    // arithmetic or logic result, one of them per instruction
    wire [DATA_W-1:0] and_res = work_reg & opnd_b;
    wire [DATA_W-1:0] alu_res = is_add ? add_sum : and_res;

    // destination routing for byte operations
    wire alu_to_work = take && (is_imm || (is_reg_alu && !instr_dest));
    wire alu_to_file = take && is_reg_alu && instr_dest;
    wire bit_write   = take && (op_bclr || op_bset);

    // a true test throws away the next instruction
    wire skip_taken = take && ((op_t_one && bit_tested) ||
                               (op_t_zero && !bit_tested));

    ////////////////////////////////////////////////////////////////////////
    // next values

    wire bus_wr_work  = reg_wr && (reg_addr == `WORK_REG_OFS);
    wire bus_wr_flags = reg_wr && (reg_addr == `FLAGS_REG_OFS);

    // execution wins over a software write in the same cycle
    assign work_next = alu_to_work ? alu_res :
                       bus_wr_work ? reg_wdata : work_reg;

    // adds touch all three flags, ands only zero, bit ops none
    assign flags_next[`FLAG_C_POS] =
        (take && is_add) ? add_c :
        bus_wr_flags ? reg_wdata[`FLAG_C_POS] : flags_reg[`FLAG_C_POS];
    assign flags_next[`FLAG_DC_POS] =
        (take && is_add) ? add_dc :
        bus_wr_flags ? reg_wdata[`FLAG_DC_POS] : flags_reg[`FLAG_DC_POS];
    assign flags_next[`FLAG_Z_POS] =
        (take && (is_add || is_and)) ? is_zero(alu_res) :
        bus_wr_flags ? reg_wdata[`FLAG_Z_POS] : flags_reg[`FLAG_Z_POS];

    // tests never write: only alu-to-file and bit ops raise the strobe
    assign file_we_next    = alu_to_file || bit_write;
    assign file_wdata_next = op_bclr ? bit_cleared :
                             op_bset ? bit_set : alu_res;

    // register port read decode, answer is zero when nothing is read
    wire [DATA_W-1:0] state_word =
        DATA_W'(state_reg == exec_pkg::st_skip_nop) << `STATE_SKIP_POS;
    assign rdata_next =
        !reg_rd ? `RDATA_IDLE :
        (reg_addr == `WORK_REG_OFS)  ? work_reg :
        (reg_addr == `FLAGS_REG_OFS) ? DATA_W'(flags_reg) :
        (reg_addr == `STATE_REG_OFS) ? state_word : `RDATA_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    // the cycle after a true test is the substituted idle cycle
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            exec_pkg::st_execute:
            begin
                if (skip_taken)
                    state_next = exec_pkg::st_skip_nop;
            end
            exec_pkg::st_skip_nop:
            begin
                state_next = exec_pkg::st_execute;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // state and programmer-visible registers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= exec_pkg::st_execute;
            work_reg  <= `WORK_RESET;
            flags_reg <= `FLAGS_RESET;
            rdata_reg <= `RDATA_IDLE;
        end
        else
        begin
            state_reg <= state_next;
            work_reg  <= work_next;
            flags_reg <= flags_next;
            rdata_reg <= rdata_next;
        end
    end

    // file write port, one cycle strobe with address and data
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            file_we_reg    <= 1'b0;
            file_waddr_reg <= '0;
            file_wdata_reg <= '0;
        end
        else
        begin
            file_we_reg    <= file_we_next;
            file_waddr_reg <= instr_file_addr;
            file_wdata_reg <= file_wdata_next;
        end
    end

    assign file_we          = file_we_reg;
    assign file_waddr       = file_waddr_reg;
    assign file_wdata       = file_wdata_reg;
    assign skip_nop         = (state_reg == exec_pkg::st_skip_nop);
    assign work_value       = work_reg;
    assign carry_flag       = flags_reg[`FLAG_C_POS];
    assign digit_carry_flag = flags_reg[`FLAG_DC_POS];
    assign zero_flag        = flags_reg[`FLAG_Z_POS];
    assign reg_rdata        = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // independent reference for the carries
    wire [DATA_W:0] chk_sum9 = {1'b0, work_reg} + {1'b0, opnd_b};
    wire [4:0]      chk_low5 = {1'b0, work_reg[3:0]} + {1'b0, opnd_b[3:0]};
    wire            chk_c    = chk_sum9[DATA_W];
    wire            chk_dc   = chk_low5[4];
    wire [DATA_W-1:0] chk_res = chk_sum9[DATA_W-1:0];
    wire            test_op  = take && (op_t_one || op_t_zero);

    sequence s_true_test;
        take && ((op_t_one && file_operand[instr_bit_idx]) ||
                 (op_t_zero && !file_operand[instr_bit_idx]));
    endsequence
    sequence s_idle_then_resume;
        skip_nop && !file_we_next ##1 !skip_nop;
    endsequence

    a_add_imm_work: assert property (
        take && op_add_imm |=> work_reg == $past(chk_res))
        else $error("add immediate sum not in working register");
    a_add_file_sum: assert property (
        take && op_add_fil && instr_dest |=> file_we &&
        file_wdata == $past(chk_res) &&
        file_waddr == $past(instr_file_addr))
        else $error("add to file wrote wrong sum or address");
    a_dest_to_work: assert property (
        take && is_reg_alu && !instr_dest |=> !file_we &&
        work_reg == $past(alu_res))
        else $error("destination bit 0 did not go to working register");
    a_add_flags: assert property (
        take && is_add |=> carry_flag == $past(chk_c) &&
        digit_carry_flag == $past(chk_dc))
        else $error("add did not update carry flags");
    a_and_imm_only_z: assert property (
        take && op_and_imm && !bus_wr_flags |=> $stable(carry_flag) &&
        $stable(digit_carry_flag) &&
        work_reg == ($past(work_reg) & $past(instr_literal)))
        else $error("and immediate wrong result or flags");
    a_and_file_route: assert property (
        take && op_and_fil && instr_dest && !bus_wr_flags |=> file_we &&
        file_wdata == ($past(work_reg) & $past(file_operand)) &&
        $stable(carry_flag))
        else $error("and with file wrong result or flags");
    a_bit_clear_zero: assert property (
        take && op_bclr && !bus_wr_flags |=> file_we &&
        !file_wdata[$past(instr_bit_idx)] && $stable(flags_reg))
        else $error("bit clear left bit set or moved flags");
    a_bit_set_one: assert property (
        take && op_bset && !bus_wr_flags |=> file_we &&
        file_wdata[$past(instr_bit_idx)] && $stable(flags_reg))
        else $error("bit set left bit clear or moved flags");
    a_skip_one_two: assert property (
        take && op_t_one && file_operand[instr_bit_idx] |=>
        s_idle_then_resume)
        else $error("skip if one did not take two cycles");
    a_skip_zero_two: assert property (
        take && op_t_zero && !file_operand[instr_bit_idx] |=>
        s_idle_then_resume)
        else $error("skip if zero did not take two cycles");
    a_test_no_side: assert property (
        test_op && !reg_wr |=> !file_we && $stable(flags_reg))
        else $error("bit test changed flags or file register");
    a_false_test_one: assert property (
        test_op && !skip_taken |=> !skip_nop)
        else $error("false test stalled a cycle");
    a_skip_is_nop: assert property (
        s_true_test ##1 (skip_nop && !reg_wr) |=> $stable(work_reg) &&
        $stable(flags_reg) && !file_we)
        else $error("discarded instruction had an effect");
    a_zero_exact: assert property (
        take && (is_add || is_and) |=> zero_flag == is_zero($past(alu_res)))
        else $error("zero flag disagrees with result");

endmodule

// ### verification/file_array_model.sv
// behavioural file register array on the far side of the execute block
// assumes: single clock; the bench preloads cells between instructions
`timescale 1ns/1ps

module file_array_model (
    // clock
    input  wire logic       sys_clk,
    // asynchronous read port
    input  wire logic [6:0] raddr,
    output logic      [7:0] rdata,
    // write port
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata
);
    logic [7:0] mem [0:127];

    // read is combinational so the operand arrives in the issue cycle
    assign rdata = mem[raddr];

    // a write lands on the edge that sees we high, not one earlier
    always @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end
endmodule

// ### verification/add_and_bit_ops_execute_tb_top.sv
// self-checking bench for the add, and and bit-operation execute stage
// assumes: the file array model answers reads in the same cycle
`timescale 1ns/1ps
`include "exec_map.svh"

module add_and_bit_ops_execute_tb_top;
    logic          sys_clk         = 1'b0;
    logic          arst_n          = 1'b0;
    logic          instr_valid     = 1'b0;
    exec_pkg::op_t instr_op        = exec_pkg::op_no_operation;
    logic [7:0]    instr_literal   = 8'h00;
    logic [6:0]    instr_file_addr = 7'h00;
    logic          instr_dest      = 1'b0;
    logic [2:0]    instr_bit_idx   = 3'h0;
    logic [3:0]    reg_addr        = 4'h0;
    logic [7:0]    reg_wdata       = 8'h00;
    logic          reg_wr          = 1'b0;
    logic          reg_rd          = 1'b0;
    logic [7:0]    file_rdata, file_wdata, work_value, reg_rdata;
    logic [6:0]    file_waddr;
    logic          file_we, skip_nop;
    logic          carry_flag, digit_carry_flag, zero_flag;
    logic [7:0]    w_exp;
    logic [2:0]    f_exp;
    int            miscompares = 0;
    int            total_checks = 0;

    ////////////////////////////////////////////////////////////////////////
    // design, far side and clock
    add_and_bit_ops_execute uut (.sys_clk(sys_clk), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_literal(instr_literal), .instr_file_addr(instr_file_addr),
        .instr_dest(instr_dest), .instr_bit_idx(instr_bit_idx),
        .file_rdata(file_rdata), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata),
        .skip_nop(skip_nop), .work_value(work_value),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    file_array_model fam (.sys_clk(sys_clk), .raddr(instr_file_addr),
        .rdata(file_rdata), .we(file_we), .waddr(file_waddr),
        .wdata(file_wdata));

    // 200 MHz
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // shared drivers and comparisons
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    // flags compared as {carry, digit carry, zero}
    task automatic chkf(input logic [2:0] exp, input string what);
        chk({5'h00, carry_flag, digit_carry_flag, zero_flag}, {5'h00, exp},
            what);
    endtask

    // offer one instruction for one cycle; returns just after its edge
    task automatic put(input exec_pkg::op_t op, input logic [7:0] lit,
                       input logic [6:0] fa, input logic d,
                       input logic [2:0] idx);
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_literal <= lit;
        instr_file_addr <= fa;
        instr_dest <= d;
        instr_bit_idx <= idx;
        #1;
    endtask

    task automatic idle();
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        instr_op <= exec_pkg::op_no_operation;
        #1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [7:0] exp,
                            input string what);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk(work_value, `WORK_RESET, "work after reset");
        chkf(`FLAGS_RESET, "flags after reset");
        reg_write(`FLAGS_REG_OFS, 8'h07);
        reg_read(`FLAGS_REG_OFS, 8'h07, "flags readback");
        @(posedge sys_clk);
        #1;
        chk(reg_rdata, `RDATA_IDLE, "read data lasts one cycle");
        reg_write(4'hF, 8'hAA);
        reg_read(4'hF, 8'h00, "unmapped read");
        reg_read(`STATE_REG_OFS, 8'h00, "state idle");
    endtask

    task automatic t_add();
        reg_write(`WORK_REG_OFS, 8'h8F);
        put(exec_pkg::op_add_immediate, 8'h71, 7'h00, 1'b0, 3'h0);
        idle();
        chk(work_value, 8'h00, "add immediate wrap");
        chkf(3'b111, "add immediate flags");
        put(exec_pkg::op_add_immediate, 8'h08, 7'h00, 1'b0, 3'h0);
        put(exec_pkg::op_add_immediate, 8'h08, 7'h00, 1'b0, 3'h0);
        idle();
        chk(work_value, 8'h10, "add immediate back to back");
        chkf(3'b010, "digit carry only");
        fam.mem[7'h7F] = 8'hF0;
        put(exec_pkg::op_add_working_to_file, 8'h00, 7'h7F, 1'b1, 3'h0);
        idle();
        chk({7'h00, file_we}, 8'h01, "add to file writes");
        chk({1'b0, file_waddr}, 8'h7F, "add to file address");
        chk(file_wdata, 8'h00, "add to file sum");
        chk(work_value, 8'h10, "work kept");
        chkf(3'b101, "add to file flags");
        idle();
        chk({7'h00, file_we}, 8'h00, "write pulse one cycle");
        put(exec_pkg::op_add_working_to_file, 8'h00, 7'h7F, 1'b0, 3'h0);
        idle();
        chk({7'h00, file_we}, 8'h00, "dest zero no file write");
        chk(work_value, 8'h10, "add to work");
        chkf(3'b000, "add to work flags");
    endtask

    task automatic t_and();
        reg_write(`FLAGS_REG_OFS, 8'h03);
        reg_write(`WORK_REG_OFS, 8'hF0);
        put(exec_pkg::op_and_immediate, 8'h0F, 7'h00, 1'b0, 3'h0);
        idle();
        chk(work_value, 8'h00, "and immediate");
        chkf(3'b111, "and sets zero only");
        reg_write(`WORK_REG_OFS, 8'h3C);
        fam.mem[7'h20] = 8'h0F;
        put(exec_pkg::op_and_working_with_file, 8'h00, 7'h20, 1'b1, 3'h0);
        idle();
        chk({file_we, file_waddr}, 8'hA0, "and to file");
        chk(file_wdata, 8'h0C, "and to file data");
        chk(work_value, 8'h3C, "and work kept");
        chkf(3'b110, "and clears zero");
        put(exec_pkg::op_and_working_with_file, 8'h00, 7'h20, 1'b0, 3'h0);
        idle();
        chk(work_value, 8'h0C, "and to work");
    endtask

    task automatic t_bits();
        reg_write(`FLAGS_REG_OFS, 8'h05);
        for (int i = 0; i < 8; i++)
        begin
            fam.mem[7'h10] = 8'hFF;
            fam.mem[7'h11] = 8'h00;
            put(exec_pkg::op_bit_clear_op, 8'h00, 7'h10, 1'b0, 3'(i));
            put(exec_pkg::op_bit_set_op, 8'h00, 7'h11, 1'b0, 3'(i));
            chk({file_we, file_waddr}, 8'h90, "clear address");
            chk(file_wdata, ~(8'h01 << i), "clear bit");
            idle();
            chk({file_we, file_waddr}, 8'h91, "set address");
            chk(file_wdata, 8'h01 << i, "set bit");
            // let the set land in the array before the next preload
            idle();
        end
        fam.mem[7'h10] = 8'hFF;
        put(exec_pkg::op_bit_clear_op, 8'h00, 7'h10, 1'b0, 3'h0);
        put(exec_pkg::op_bit_clear_op, 8'h00, 7'h10, 1'b0, 3'h1);
        idle();
        chk(file_wdata, 8'hFC, "pending write forwarded");
        chkf(3'b101, "bit ops keep flags");
    endtask

    // test then an add of one; a true test must swallow the add
    task automatic t_skip();
        logic sk;
        fam.mem[7'h30] = 8'h5A;
        reg_write(`FLAGS_REG_OFS, 8'h00);
        reg_write(`WORK_REG_OFS, 8'h0E);
        w_exp = 8'h0E;
        f_exp = 3'b000;
        for (int i = 0; i < 16; i++)
        begin
            sk = (i < 8) ? fam.mem[7'h30][i % 8] : !fam.mem[7'h30][i % 8];
            put((i < 8) ? exec_pkg::op_test_bit_skip_if_one
                        : exec_pkg::op_test_bit_skip_if_zero,
                8'h00, 7'h30, 1'b1, 3'(i % 8));
            put(exec_pkg::op_add_immediate, 8'h01, 7'h30, 1'b0, 3'h0);
            chk({7'h00, skip_nop}, {7'h00, sk}, "skip decision");
            chk({7'h00, file_we}, 8'h00, "test writes nothing");
            chkf(f_exp, "test keeps flags");
            idle();
            if (!sk)
            begin
                f_exp = {w_exp == 8'hFF, w_exp[3:0] == 4'hF, w_exp == 8'hFF};
                w_exp = w_exp + 8'h01;
            end
            chk(work_value, w_exp, "next instruction fate");
            chkf(f_exp, "flags after second cycle");
            chk({7'h00, skip_nop}, 8'h00, "idle cycle only one");
        end
        reg_read(`WORK_REG_OFS, w_exp, "work readback");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict, watchdog and main sequence
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the tests need well under a thousand cycles
    initial
    begin
        #25000;
        miscompares++;
        final_report();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1;
        t_reset();
        t_add();
        t_and();
        t_bits();
        t_skip();
        final_report();
    end
endmodule
